// file: hw/twm_regs.svh
// Constants for the two-wire master: field widths, reset values and timing limits.
`ifndef TWM_REGS_SVH
`define TWM_REGS_SVH
`define TWM_DIV_W 8
`define TWM_EXP_W 3
`define TWM_CNT_W 15
`define TWM_LEN_W 4
`define TWM_FIFO_DEPTH 4
`define TWM_PHASE_MIN 15'h0002
`define TWM_ACK_BIT 4'h8
`define TWM_LAST_DATA_BIT 4'h7
`define TWM_TRANSFER_COMPLETE_FLAG_RST 1'b1
`define TWM_TRANSMIT_READY_FLAG_RST 1'b1
`endif

// file: hw/twm_pkg.sv
// Types shared by the two-wire master files.
package twm_pkg;
	// One-hot frame sequencer states.
	typedef enum logic [3:0] {
		TWM_IDLE = 4'h1,
		TWM_START = 4'h2,
		TWM_BIT = 4'h4,
		TWM_STOP = 4'h8
	} twm_state_t;
	// What the byte now on the wire carries.
	typedef enum logic [2:0] {
		TWM_K_ADDR = 3'h1,
		TWM_K_WR = 3'h2,
		TWM_K_RD = 3'h4
	} twm_kind_t;
endpackage

// file: hw/twm_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module twm_fifo import twm_pkg::*; #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clocking.
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic flush,
	// Filling side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];  // Storage words.
	logic [AW-1:0] wr_q;  // Write index.
	logic [AW-1:0] rd_q;  // Read index.
	logic [AW:0] cnt_q;  // Words held.
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// Pointer wrap, used by both indices.
	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];

	// Storage is written only on push; it needs no reset because empty hides it.
	always_ff @(posedge ref_clk) begin
		if (ce && push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Indices and occupancy.
	always_ff @(posedge ref_clk) begin
		if (reset || (ce && flush)) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (ce) begin
			if (push) begin
				wr_q <= nxt(wr_q);
			end
			if (pop) begin
				rd_q <= nxt(rd_q);
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// file: hw/twm_master.sv
// Two-wire serial master with its documented quirks kept.
// Documented rules and quirks
// [R1] Software keeps scaled dividers at most 8191.
// [R2] Master disable freezes transfer, leaves flags set.
// [R3] Software finishes transfer, masks interrupts before disabling.
// [R4] Nack rises with completion, status read clears.
// [R5] Status read before completion loses the nack.
// [R6] Software waits for completion before reading status.
// [R7] Holding register loads every byte, flags untouched.
// [R8] Software reads received byte before next transmit.
// [R9] Reset mid-frame with clock low locks starts.
// [R10] Phase lengths are dividers shifted by exponent; the code raises any result below two cycles to two.
`timescale 1ns/1ps
`include "twm_regs.svh"
module twm_master import twm_pkg::*; (
	// Clocking.
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic ce,
	// Commands, one-cycle pulses.
	input wire logic start_cmd,
	input wire logic master_disable_bit,
	input wire logic master_enable_cmd,
	input wire logic software_reset_command,
	input wire logic status_read,
	input wire logic rhr_read,
	// Frame setup.
	input wire logic [6:0] slave_addr,
	input wire logic read_not_write,
	input wire logic [`TWM_LEN_W-1:0] read_len,
	input wire logic [`TWM_DIV_W-1:0] clock_low_divider,
	input wire logic [`TWM_DIV_W-1:0] clock_high_divider,
	input wire logic [`TWM_EXP_W-1:0] clock_divider_exponent,
	// Transmit byte stream.
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	// Status.
	output logic transfer_complete_flag,
	output logic transmit_ready_flag,
	output logic receive_ready_flag,
	output logic nack_flag,
	output logic overrun_flag,
	output logic start_locked,
	output logic frozen,
	output logic [7:0] receive_holding_register,
	// Open-drain bus pins.
	input wire logic serial_clock_line_in,
	output logic serial_clock_line_oe,
	input wire logic serial_data_in,
	output logic serial_data_oe
);
	twm_state_t state_q;  // Frame sequencer.
	twm_kind_t kind_q;  // Role of the current byte.
	logic [`TWM_CNT_W-1:0] cnt_q;  // Cycles left in this phase.
	logic half_q;  // High when the clock phase is the released one.
	logic [3:0] bit_q;  // Bit index, 8 is the acknowledge slot.
	logic [1:0] sub_q;  // Step inside the stop sequence.
	logic [7:0] shift_q;  // Byte being shifted.
	logic [`TWM_LEN_W-1:0] left_q;  // Read bytes still to take.
	logic drive_pend_q;  // Data line update owed one cycle into a low phase.
	logic scl_oe_q;
	logic sda_oe_q;
	logic frozen_q;
	logic lock_q;
	logic pend_nack_q;  // Missing acknowledge seen, not yet reported.
	logic nack_q;
	logic transfer_complete_flag_q;
	logic transmit_ready_flag_q;
	logic receive_ready_flag_q;
	logic ovr_q;
	logic [7:0] rhr_q;
	// Pin synchronisers; only the second stages are read.
	logic scl_m_q;
	logic scl_s_q;
	logic sda_m_q;
	logic sda_s_q;
	// Transmit FIFO draining side.
	logic fifo_valid;
	logic [7:0] fifo_data;

	// Phase length in system cycles, never below two so a data change
	// always has a cycle of low clock before the clock is released.
	function automatic logic [`TWM_CNT_W-1:0] phase_len(input logic [`TWM_DIV_W-1:0] d,
			input logic [`TWM_EXP_W-1:0] e);
		logic [`TWM_CNT_W-1:0] v;
		v = `TWM_CNT_W'(d) << e;  // see [R10]
		phase_len = (v < `TWM_PHASE_MIN) ? `TWM_PHASE_MIN : v;
	endfunction

	// Loaded counts are one less than the length so a tick ends the phase.
	wire [`TWM_CNT_W-1:0] lo_load = phase_len(clock_low_divider, clock_divider_exponent) - 1'b1;
	wire [`TWM_CNT_W-1:0] hi_load = phase_len(clock_high_divider, clock_divider_exponent) - 1'b1;
	// The sequencer moves only while a frame runs and is not frozen.
	wire run = (state_q != TWM_IDLE) && !frozen_q;  // see [R2]
	// A released clock held low by a slave stretches the high phase.
	wire stretch = half_q && !scl_s_q;
	wire tick = run && (cnt_q == '0) && !stretch;
	wire is_ack = (bit_q == `TWM_ACK_BIT);
	wire last_data = (bit_q == `TWM_LAST_DATA_BIT);
	wire bit_hi_tick = tick && (state_q == TWM_BIT) && half_q;
	wire ack_tick = bit_hi_tick && is_ack;
	wire rd_last = (left_q <= `TWM_LEN_W'(1));
	wire got_nack = ack_tick && (kind_q != TWM_K_RD) && sda_s_q;
	wire go_read = ack_tick && !got_nack && (kind_q == TWM_K_ADDR) && read_not_write;
	wire go_write = ack_tick && !got_nack && (kind_q != TWM_K_RD) && !go_read && fifo_valid;
	wire rd_more = ack_tick && (kind_q == TWM_K_RD) && !rd_last;
	wire go_stop = ack_tick && !go_read && !go_write && !rd_more;
	wire byte_done = bit_hi_tick && last_data && (kind_q != TWM_K_ADDR);
	wire [7:0] rx_byte = {shift_q[6:0], sda_s_q};
	wire start_ok = start_cmd && (state_q == TWM_IDLE) && !frozen_q && !lock_q;  // see [R9]
	wire done = tick && (state_q == TWM_STOP) && (sub_q == 2'h2);
	// Level to put on the data line for the coming bit: acknowledge every
	// read byte but the last, send the top bit of address and write bytes,
	// and release the line for the data bits of a read byte.
	wire bit_low = is_ack ? ((kind_q == TWM_K_RD) && !rd_last) :
		((kind_q != TWM_K_RD) && !shift_q[7]);
	wire want_low = (state_q == TWM_STOP) ? 1'b1 : bit_low;
	wire srst = software_reset_command;

	twm_fifo #(.WIDTH(8), .DEPTH(`TWM_FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.reset(reset),
		.ce(ce),
		.flush(srst),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_data),
		.out_valid(fifo_valid),
		.out_ready(go_write),
		.out_data(fifo_data)
	);

	// Two-stage synchronisers for the bus lines.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else if (ce) begin
			scl_m_q <= serial_clock_line_in;
			scl_s_q <= scl_m_q;
			sda_m_q <= serial_data_in;
			sda_s_q <= sda_m_q;
		end
	end

	// Frame sequencer and bit engine. While frozen nothing here moves, so
	// the bus is left exactly as it stood; that is why software should
	// wait for completion before disabling.
	always_ff @(posedge ref_clk) begin
		if (reset || (ce && srst)) begin
			state_q <= TWM_IDLE;
			kind_q <= TWM_K_ADDR;
			cnt_q <= '0;
			half_q <= 1'b1;
			bit_q <= '0;
			sub_q <= '0;
			shift_q <= '0;
			left_q <= '0;
			drive_pend_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (ce) begin
			if (start_ok) begin
				// Start condition: data falls while clock stays released.
				state_q <= TWM_START;
				kind_q <= TWM_K_ADDR;
				shift_q <= {slave_addr, read_not_write};
				left_q <= read_len;
				sda_oe_q <= 1'b1;
				half_q <= 1'b1;
				cnt_q <= hi_load;
			end else if (run && !tick) begin
				if (!stretch) begin
					cnt_q <= cnt_q - 1'b1;
				end
				if (drive_pend_q) begin
					sda_oe_q <= want_low;
					drive_pend_q <= 1'b0;
				end
			end else if (tick && !half_q) begin
				// End of a low phase: release the clock.
				scl_oe_q <= 1'b0;
				half_q <= 1'b1;
				cnt_q <= hi_load;
				if (state_q == TWM_STOP) begin
					sub_q <= 2'h1;
				end
			end else if (tick) begin
				// End of a high phase.
				if (state_q == TWM_STOP) begin
					sda_oe_q <= 1'b0;
					cnt_q <= hi_load;
					sub_q <= sub_q + 1'b1;
					if (sub_q == 2'h2) begin
						state_q <= TWM_IDLE;
					end
				end else begin
					scl_oe_q <= 1'b1;
					half_q <= 1'b0;
					cnt_q <= lo_load;
					drive_pend_q <= 1'b1;
					state_q <= go_stop ? TWM_STOP : TWM_BIT;
					sub_q <= '0;
					if (state_q == TWM_START || ack_tick) begin
						bit_q <= '0;
					end else begin
						bit_q <= bit_q + 1'b1;
						shift_q <= rx_byte;
					end
					if (go_write) begin
						kind_q <= TWM_K_WR;
						shift_q <= fifo_data;
					end
					if (go_read || rd_more) begin
						kind_q <= TWM_K_RD;
					end
					if (rd_more) begin
						left_q <= left_q - 1'b1;
					end
				end
			end
		end
	end

	// Software status flags. Hardware sets win over clears in the same cycle.
	always_ff @(posedge ref_clk) begin
		if (reset || (ce && srst)) begin
			transfer_complete_flag_q <= `TWM_TRANSFER_COMPLETE_FLAG_RST;
			transmit_ready_flag_q <= `TWM_TRANSMIT_READY_FLAG_RST;
			receive_ready_flag_q <= 1'b0;
			ovr_q <= 1'b0;
			nack_q <= 1'b0;
			pend_nack_q <= 1'b0;
			rhr_q <= '0;
		end else if (ce) begin
			// The transmit ready flag holds still while frozen instead of being reset.
			if (!frozen_q) begin
				transmit_ready_flag_q <= tx_ready;  // see [R2]
			end
			if (start_ok) begin
				transfer_complete_flag_q <= 1'b0;
			end else if (done) begin
				transfer_complete_flag_q <= 1'b1;
			end
			// An early status read drops the pending nack for good.
			if (got_nack) begin
				pend_nack_q <= 1'b1;
			end else if (status_read || start_ok) begin
				pend_nack_q <= 1'b0;  // see [R5]
			end
			// Nack is reported only together with completion.
			if (done) begin
				nack_q <= pend_nack_q || got_nack;  // see [R4]
			end else if (status_read) begin
				nack_q <= 1'b0;  // see [R4]
			end
			// The holding register takes every data byte, sent or received;
			// only received bytes raise ready or overrun.
			if (byte_done) begin
				rhr_q <= rx_byte;  // see [R7]
			end
			if (byte_done && kind_q == TWM_K_RD) begin
				receive_ready_flag_q <= 1'b1;
				ovr_q <= ovr_q || receive_ready_flag_q;
			end else if (rhr_read) begin
				receive_ready_flag_q <= 1'b0;
			end
		end
	end

	// Freeze and lock control. The lock models the controller wedging when
	// reset hits while it holds the clock low; only the system reset frees it.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			frozen_q <= 1'b0;
			lock_q <= 1'b0;
		end else if (ce) begin
			if (srst && state_q != TWM_IDLE && scl_oe_q) begin
				lock_q <= 1'b1;  // see [R9]
			end
			if (master_disable_bit) begin
				frozen_q <= 1'b1;  // see [R2]
			end else if (master_enable_cmd || srst) begin
				frozen_q <= 1'b0;
			end
		end
	end

	assign transfer_complete_flag = transfer_complete_flag_q;
	assign transmit_ready_flag = transmit_ready_flag_q;
	assign receive_ready_flag = receive_ready_flag_q;
	assign nack_flag = nack_q;
	assign overrun_flag = ovr_q;
	assign start_locked = lock_q;
	assign frozen = frozen_q;
	assign receive_holding_register = rhr_q;
	assign serial_clock_line_oe = scl_oe_q;
	assign serial_data_oe = sda_oe_q;
endmodule

// file: tb/twm_master_assertions.sv
// Concurrent checks on the two-wire master, bound to its ports.
`timescale 1ns/1ps
`include "twm_regs.svh"
module twm_master_checker (
	// Clocking.
	input wire logic ref_clk,
	input wire logic reset,
	// Commands and setup.
	input wire logic start_cmd,
	input wire logic master_disable_bit,
	input wire logic master_enable_cmd,
	input wire logic software_reset_command,
	input wire logic status_read,
	input wire logic read_not_write,
	input wire logic [`TWM_DIV_W-1:0] clock_low_divider,
	input wire logic [`TWM_EXP_W-1:0] clock_divider_exponent,
	// Status and pins.
	input wire logic transfer_complete_flag,
	input wire logic transmit_ready_flag,
	input wire logic receive_ready_flag,
	input wire logic nack_flag,
	input wire logic start_locked,
	input wire logic frozen,
	input wire logic serial_clock_line_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Length of the running low phase; all ones marks a phase spoilt by a freeze.
	logic [15:0] low_q;
	logic [15:0] low_d;
	logic [14:0] low_len;
	logic [14:0] low_exp;
	assign low_len = 15'(clock_low_divider) << clock_divider_exponent;
	assign low_exp = (low_len < 15'h0002) ? 15'h0002 : low_len;
	assign low_d = !serial_clock_line_oe ? 16'h0000 :
		(frozen || master_disable_bit || low_q == 16'hffff) ? 16'hffff : low_q + 16'h0001;
	// A software reset cuts a phase short, so the count restarts there.
	always_ff @(posedge ref_clk) begin
		if (reset || software_reset_command) begin
			low_q <= 16'h0000;
		end else begin
			low_q <= low_d;
		end
	end
	property p_phase_low;
		$fell(serial_clock_line_oe) && low_q != 16'hffff && !$past(software_reset_command)
			|-> low_q == {1'b0, low_exp};
	endproperty
	a_phase_low: assert property (p_phase_low) else $error("low phase length wrong");
	property p_nack_with_comp;
		$rose(nack_flag) |-> $rose(transfer_complete_flag);
	endproperty
	a_nack_with_comp: assert property (p_nack_with_comp) else $error("nack apart");
	property p_nack_clear;
		status_read && !frozen && !master_disable_bit
			|=> !nack_flag || $rose(transfer_complete_flag);
	endproperty
	a_nack_clear: assert property (p_nack_clear) else $error("nack kept");
	property p_freeze_now;
		master_disable_bit && !software_reset_command |=> frozen;
	endproperty
	a_freeze_now: assert property (p_freeze_now) else $error("disable not taken");
	property p_freeze_hold;
		frozen && !master_enable_cmd && !software_reset_command |=> $stable(serial_clock_line_oe)
			&& $stable(transfer_complete_flag) && $stable(transmit_ready_flag);
	endproperty
	a_freeze_hold: assert property (p_freeze_hold) else $error("moved while frozen");
	property p_lock_set;
		software_reset_command && serial_clock_line_oe && !transfer_complete_flag |=> start_locked;
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("lock not set");
	property p_lock_stays;
		start_locked |=> start_locked [*8];
	endproperty
	a_lock_stays: assert property (p_lock_stays) else $error("lock released");
	property p_lock_blocks;
		start_locked && start_cmd |=> transfer_complete_flag;
	endproperty
	a_lock_blocks: assert property (p_lock_blocks) else $error("locked start taken");
	property p_rx_only_read;
		$rose(receive_ready_flag) |-> read_not_write;
	endproperty
	a_rx_only_read: assert property (p_rx_only_read) else $error("rx flag on write");
endmodule
bind twm_master twm_master_checker chk_i (.ref_clk, .reset, .start_cmd, .master_disable_bit,
	.master_enable_cmd, .software_reset_command, .status_read, .read_not_write,
	.clock_low_divider, .clock_divider_exponent, .transfer_complete_flag, .transmit_ready_flag,
	.receive_ready_flag, .nack_flag, .start_locked, .frozen, .serial_clock_line_oe);

// file: tb/twm_slave.sv
// Behavioural serial slave that acknowledges, refuses and returns one byte.
`timescale 1ns/1ps
module twm_slave (
	// Bus levels.
	input wire logic scl,
	input wire logic sda,
	// Behaviour.
	input wire logic nack_mode,
	input wire logic [7:0] rd_byte,
	output logic sda_oe
);
	int cnt = 0;
	logic [7:0] sh = 8'h00;
	logic rd = 1'b0;
	logic first = 1'b0;
	initial sda_oe = 1'b0;
	// Start and stop conditions restart the byte count.
	always @(negedge sda) if (scl) begin
		cnt = 0;
		first = 1'b1;
		rd = 1'b0;
	end
	always @(posedge sda) if (scl) begin
		cnt = 0;
		rd = 1'b0;
		sda_oe = 1'b0;
	end
	// A released ack on a read byte means the master wants no more.
	always @(posedge scl) begin
		if (cnt == 8 && rd && !first && sda) rd = 1'b0;
		if (cnt < 8) sh = {sh[6:0], sda};
		cnt = cnt + 1;
	end
	// Data only changes while the clock is low.
	always @(negedge scl) begin
		if (cnt == 8) begin
			if (first) rd = sh[0];
			sda_oe = (rd && !first) ? 1'b0 : !nack_mode;
		end else begin
			if (cnt == 9) begin
				cnt = 0;
				first = 1'b0;
			end
			sda_oe = rd && !first && cnt < 8 && !rd_byte[7 - cnt];
		end
	end
endmodule

// file: tb/twm_master_bench.sv
// Bench for the two-wire master with a slave model on the bus.
`timescale 1ns/1ps
module twm_master_bench;
	logic ref_clk = 1'b0, reset = 1'b1, ce = 1'b1, start_cmd = 1'b0, master_disable_bit = 1'b0;
	logic master_enable_cmd = 1'b0, software_reset_command = 1'b0, status_read = 1'b0;
	logic rhr_read = 1'b0, read_not_write = 1'b0, tx_valid = 1'b0, nack_mode = 1'b0, o;
	logic [6:0] slave_addr = 7'h2a;
	logic [3:0] read_len = 4'h1;
	logic [7:0] clock_low_divider = 8'h04, clock_high_divider = 8'h04, tx_data = 8'h00;
	logic [2:0] clock_divider_exponent = 3'h1;
	logic tx_ready, transfer_complete_flag, transmit_ready_flag, receive_ready_flag, nack_flag;
	logic overrun_flag, start_locked, frozen, serial_clock_line_oe, serial_data_oe, slave_oe;
	logic [7:0] receive_holding_register;
	wire logic serial_clock_line_in, serial_data_in;
	int n_fail = 0, n_checks = 0, cyc = 0;
	// Open-drain lines with pull-ups; both parties can only pull low.
	assign serial_clock_line_in = !serial_clock_line_oe;
	assign serial_data_in = !(serial_data_oe || slave_oe);
	always #2 ref_clk = ~ref_clk;
	twm_master dut (.ref_clk, .reset, .ce, .start_cmd, .master_disable_bit, .master_enable_cmd,
		.software_reset_command, .status_read, .rhr_read, .slave_addr, .read_not_write,
		.read_len, .clock_low_divider, .clock_high_divider, .clock_divider_exponent,
		.tx_valid, .tx_ready, .tx_data, .transfer_complete_flag, .transmit_ready_flag,
		.receive_ready_flag, .nack_flag, .overrun_flag, .start_locked, .frozen,
		.receive_holding_register, .serial_clock_line_in, .serial_clock_line_oe,
		.serial_data_in, .serial_data_oe);
	twm_slave slave (.scl(serial_clock_line_in), .sda(serial_data_in), .nack_mode,
		.rd_byte(8'ha5), .sda_oe(slave_oe));
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// A hung handshake ends the run as a mismatch.
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up;
		end
	end
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Inputs always change one nanosecond after the edge.
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task push(input logic [7:0] d);
		tx_valid = 1'b1;
		tx_data = d;
		while (tx_ready !== 1'b1) tick(1);
		tick(1);
		tx_valid = 1'b0;
		// Let an edge pass so a following push never raises valid in the same step.
		tick(1);
	endtask
	task go(input logic r);
		read_not_write = r;
		start_cmd = 1'b1;
		tick(1);
		start_cmd = 1'b0;
	endtask
	task automatic wait_comp();
		int k;
		k = 0;
		while (transfer_complete_flag !== 1'b1 && k < 3000) begin
			tick(1);
			k++;
		end
		// A frame that never ends is a mismatch and closes the run.
		if (k == 3000) begin
			n_fail++;
			wrap_up;
		end
	endtask
	initial begin
		tick(3);
		reset = 1'b0;
		chk("comp", transfer_complete_flag, 1'b1);
		chk("transmit_ready_flag", transmit_ready_flag, 1'b1);
		// Read one byte, then consume it.
		go(1'b1);
		wait_comp();
		chk("receive_ready_flag", receive_ready_flag, 1'b1);
		chk("rhr", receive_holding_register, 8'ha5);
		rhr_read = 1'b1;
		tick(1);
		rhr_read = 1'b0;
		chk("receive_ready_flag", receive_ready_flag, 1'b0);
		// Fill the buffer until it refuses, then write it all out.
		for (int i = 1; i <= 4; i++) push(8'(i * 17));
		chk("ready", tx_ready, 1'b0);
		go(1'b0);
		wait_comp();
		chk("ready", tx_ready, 1'b1);
		chk("rhr", receive_holding_register, 8'h44);
		chk("receive_ready_flag", receive_ready_flag, 1'b0);
		chk("ovr", overrun_flag, 1'b0);
		chk("nack", nack_flag, 1'b0);
		// Refused address: flag rises with completion and a read clears it.
		nack_mode = 1'b1;
		go(1'b0);
		wait_comp();
		chk("nack", nack_flag, 1'b1);
		status_read = 1'b1;
		tick(1);
		status_read = 1'b0;
		chk("nack", nack_flag, 1'b0);
		// Polling status during the frame loses the refusal.
		go(1'b0);
		status_read = 1'b1;
		wait_comp();
		status_read = 1'b0;
		chk("nack", nack_flag, 1'b0);
		nack_mode = 1'b0;
		// Disable mid-frame freezes everything until re-enabled; the wait is
		// longer than a whole frame, so a missed freeze would show completion.
		push(8'h66);
		go(1'b0);
		tick(40);
		master_disable_bit = 1'b1;
		tick(1);
		master_disable_bit = 1'b0;
		o = serial_clock_line_oe;
		tick(400);
		chk("frozen", frozen, 1'b1);
		chk("comp", transfer_complete_flag, 1'b0);
		chk("scl", serial_clock_line_oe, o);
		master_enable_cmd = 1'b1;
		tick(1);
		master_enable_cmd = 1'b0;
		wait_comp();
		chk("comp", transfer_complete_flag, 1'b1);
		// Disabling only after completion, as software should, keeps both flags set.
		master_disable_bit = 1'b1;
		tick(1);
		master_disable_bit = 1'b0;
		tick(1);
		chk("frozen", frozen, 1'b1);
		chk("comp", transfer_complete_flag, 1'b1);
		chk("transmit_ready_flag", transmit_ready_flag, 1'b1);
		master_enable_cmd = 1'b1;
		tick(1);
		master_enable_cmd = 1'b0;
		// Software reset while the clock is held low locks out new frames.
		push(8'h88);
		go(1'b0);
		while (serial_clock_line_oe !== 1'b1) tick(1);
		software_reset_command = 1'b1;
		tick(1);
		software_reset_command = 1'b0;
		chk("locked", start_locked, 1'b1);
		go(1'b0);
		tick(20);
		chk("comp", transfer_complete_flag, 1'b1);
		chk("sda", serial_data_oe, 1'b0);
		wrap_up;
	end
endmodule
